// ### prlc_top.v
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// R01: Extended range option per axis; 0 off, 1 on; off after reset.
// R02: Range off: pulse targets accepted only in signed 32-bit interval.
// R03: Range on: pulse targets accepted in signed 48-bit interval.
// R04: Targets converted from user units to pulses; out of range flags error.
// R05: Range off with default limits: software limit detection skipped.
// R06: Range on with default limits: enforced; excess raises error, abrupt stop.
// R07: Equal upper and lower limits disable software limit detection.
// R08: Auxiliary quantities stay within signed 32-bit pulse range always.
// R09: Range checked before start; rejected command causes no motion, reports error.
`include "prlc_consts.vh"

module prlc_top #(
	parameter AUX_N = 8
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Axis status
	output reg         irq_o,
	output reg         busy_o,
	output reg         stop_o,
	output reg  [47:0] pos_o
);

	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_MOVE = 2'b10;

	// Register state
	reg        ext_q;
	reg [63:0] tgt_q;
	reg [15:0] scale_q;
	reg [47:0] swup_q;
	reg [47:0] swlo_q;
	reg [3:0]  ev_q;
	reg [3:0]  mask_q;
	reg [2:0]  aux_idx_q;
	reg [31:0] aux_mem [0:AUX_N-1];
	reg        range_err_q;
	reg        swlim_err_q;
	reg        aux_err_q;

	// Motion state
	reg [1:0]  state_q;
	reg [47:0] pos_q;
	reg [47:0] goal_q;

	// Bus decode
	wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire       wr      = req & wb_we_i;
	wire       rd      = req & ~wb_we_i;
	wire [31:0] wmask;

	// Byte lane mask, one lane per step
	genvar bi;
	generate
		for (bi = 0; bi < 4; bi = bi + 1) begin : g_lane
			assign wmask[bi*8 +: 8] = {8{wb_sel_i[bi]}};
		end
	endgenerate

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [31:0] m;
		begin
			merge = (old & ~m) | (nw & m);
		end
	endfunction

	// Target conversion to pulse units
	wire signed [80:0] prod = $signed(tgt_q) * $signed({1'b0, scale_q});
	wire       fit48 = (&prod[80:47]) | ~(|prod[80:47]);
	wire       fit32 = (&prod[80:31]) | ~(|prod[80:31]);
	wire       tgt_ok = ext_q ? fit48 : fit32; // R02 R03 R04

	// Auxiliary conversion, always 32-bit limited
	wire [31:0] aux_in  = merge(32'h0000_0000, wb_dat_i, wmask);
	wire signed [48:0] aux_prod = $signed(aux_in) * $signed({1'b0, scale_q});
	wire       aux_ok = (&aux_prod[48:31]) | ~(|aux_prod[48:31]); // R08

	// Software limit enable
	wire       lim_eq  = (swup_q == swlo_q); // R07
	wire       lim_def = (swup_q == `PRLC_MAX32) && (swlo_q == `PRLC_MIN32);
	wire       lim_on  = ~lim_eq & (ext_q | ~lim_def); // R05 R06 R07

	// Next step toward goal
	wire       dir_up   = $signed(goal_q) > $signed(pos_q);
	wire [47:0] pos_d   = dir_up ? pos_q + `PRLC_STEP : pos_q - `PRLC_STEP;
	wire       at_goal  = (pos_q == goal_q);
	wire       over_lim = lim_on & (($signed(pos_d) > $signed(swup_q)) |
	                      ($signed(pos_d) < $signed(swlo_q))); // R06

	// Control writes
	wire       ctrl_wr  = wr & (wb_adr_i == `PRLC_CTRL);
	wire       start    = ctrl_wr & wb_sel_i[0] & wb_dat_i[`PRLC_CTRL_START];
	wire       stop_req = ctrl_wr & wb_sel_i[0] & wb_dat_i[`PRLC_CTRL_STOP];
	wire       aux_wr   = wr & (wb_adr_i == `PRLC_AUX_VAL);

	// Event pulses
	reg  [3:0] ev_set;
	always @* begin
		ev_set = 4'h0;
		ev_set[`PRLC_EV_DONE]  = (state_q == ST_MOVE) & at_goal;
		ev_set[`PRLC_EV_RANGE] = start & (state_q == ST_IDLE) & ~tgt_ok; // R09
		ev_set[`PRLC_EV_SWLIM] = (state_q == ST_MOVE) & ~at_goal & over_lim; // R06
		ev_set[`PRLC_EV_AUX]   = aux_wr & ~aux_ok; // R08
	end

	wire       stat_rd = rd & (wb_adr_i == `PRLC_IRQ_STAT);

	// Sticky event bits, set wins over read clear
	genvar gi;
	generate
		for (gi = 0; gi < `PRLC_NUM_EV; gi = gi + 1) begin : g_ev
			always @(posedge clk_i) begin
				if (rst_i) begin
					ev_q[gi] <= 1'b0;
				end else if (ev_set[gi]) begin
					ev_q[gi] <= 1'b1;
				end else if (stat_rd) begin
					ev_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Write strobes per register
	wire        ext_wr     = ctrl_wr & wb_sel_i[0] & (state_q == ST_IDLE);
	wire        tgt_lo_wr  = wr & (wb_adr_i == `PRLC_TGT_LO);
	wire        tgt_hi_wr  = wr & (wb_adr_i == `PRLC_TGT_HI);
	wire        scale_wr   = wr & (wb_adr_i == `PRLC_SCALE);
	wire        swup_lo_wr = wr & (wb_adr_i == `PRLC_SWUP_LO);
	wire        swup_hi_wr = wr & (wb_adr_i == `PRLC_SWUP_HI);
	wire        swlo_lo_wr = wr & (wb_adr_i == `PRLC_SWLO_LO);
	wire        swlo_hi_wr = wr & (wb_adr_i == `PRLC_SWLO_HI);
	wire        mask_wr    = wr & (wb_adr_i == `PRLC_IRQ_MASK) & wb_sel_i[0];
	wire        idx_wr     = wr & (wb_adr_i == `PRLC_AUX_IDX) & wb_sel_i[0];

	// Narrow registers merged as words, then cut to width
	wire [31:0] scale_m    = merge({16'h0000, scale_q}, wb_dat_i, wmask);
	wire [31:0] swup_hi_m  = merge({16'h0000, swup_q[47:32]}, wb_dat_i, wmask);
	wire [31:0] swlo_hi_m  = merge({16'h0000, swlo_q[47:32]}, wb_dat_i, wmask);

	// Extended range option, changed only while idle
	always @(posedge clk_i) begin
		if (rst_i) begin
			ext_q <= `PRLC_EXT_RST; // R01
		end else if (ext_wr) begin
			ext_q <= wb_dat_i[`PRLC_CTRL_EXT]; // R01
		end
	end

	// Target in user units
	always @(posedge clk_i) begin
		if (rst_i) begin
			tgt_q <= 64'h0000_0000_0000_0000;
		end else begin
			if (tgt_lo_wr) begin
				tgt_q[31:0] <= merge(tgt_q[31:0], wb_dat_i, wmask);
			end
			if (tgt_hi_wr) begin
				tgt_q[63:32] <= merge(tgt_q[63:32], wb_dat_i, wmask);
			end
		end
	end

	// Pulses per user unit
	always @(posedge clk_i) begin
		if (rst_i) begin
			scale_q <= `PRLC_SCALE_RST;
		end else if (scale_wr) begin
			scale_q <= scale_m[15:0];
		end
	end

	// Software upper limit
	always @(posedge clk_i) begin
		if (rst_i) begin
			swup_q <= `PRLC_SWUP_RST;
		end else begin
			if (swup_lo_wr) begin
				swup_q[31:0] <= merge(swup_q[31:0], wb_dat_i, wmask);
			end
			if (swup_hi_wr) begin
				swup_q[47:32] <= swup_hi_m[15:0];
			end
		end
	end

	// Software lower limit
	always @(posedge clk_i) begin
		if (rst_i) begin
			swlo_q <= `PRLC_SWLO_RST;
		end else begin
			if (swlo_lo_wr) begin
				swlo_q[31:0] <= merge(swlo_q[31:0], wb_dat_i, wmask);
			end
			if (swlo_hi_wr) begin
				swlo_q[47:32] <= swlo_hi_m[15:0];
			end
		end
	end

	// Interrupt mask
	always @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= 4'h0;
		end else if (mask_wr) begin
			mask_q <= wb_dat_i[3:0];
		end
	end

	// Auxiliary table index
	always @(posedge clk_i) begin
		if (rst_i) begin
			aux_idx_q <= 3'h0;
		end else if (idx_wr) begin
			aux_idx_q <= wb_dat_i[2:0];
		end
	end

	// Auxiliary table, stored only when in 32-bit range
	always @(posedge clk_i) begin
		if (aux_wr && aux_ok) begin
			aux_mem[aux_idx_q] <= aux_prod[31:0]; // R08
		end
	end

	// Error flags for status
	always @(posedge clk_i) begin
		if (rst_i) begin
			range_err_q <= 1'b0;
			swlim_err_q <= 1'b0;
			aux_err_q   <= 1'b0;
		end else begin
			if (start && state_q == ST_IDLE) begin
				range_err_q <= ~tgt_ok; // R09
				swlim_err_q <= 1'b0;
			end else if (ev_set[`PRLC_EV_SWLIM]) begin
				swlim_err_q <= 1'b1; // R06
			end
			if (aux_wr) begin
				aux_err_q <= ~aux_ok;
			end
		end
	end

	// Motion sequencer
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			pos_q   <= 48'h0000_0000_0000;
			goal_q  <= 48'h0000_0000_0000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start && tgt_ok) begin
						goal_q  <= prod[47:0]; // R04
						state_q <= ST_MOVE;
					end
				end
				ST_MOVE: begin
					if (at_goal || stop_req) begin
						state_q <= ST_IDLE;
					end else if (over_lim) begin
						state_q <= ST_IDLE; // R06
					end else begin
						pos_q <= pos_d;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Status word
	wire [31:0] status_w;
	assign status_w[0]    = 1'b0;
	assign status_w[1]    = range_err_q; // R09
	assign status_w[2]    = swlim_err_q;
	assign status_w[3]    = aux_err_q;
	assign status_w[4]    = (state_q == ST_MOVE);
	assign status_w[5]    = lim_on;
	assign status_w[31:6] = 26'h000_0000;

	// Read mux
	reg [31:0] rdata;
	always @* begin
		rdata = 32'h0000_0000;
		case (wb_adr_i)
			`PRLC_CTRL:     rdata = {31'h0000_0000, ext_q};
			`PRLC_TGT_LO:   rdata = tgt_q[31:0];
			`PRLC_TGT_HI:   rdata = tgt_q[63:32];
			`PRLC_SCALE:    rdata = {16'h0000, scale_q};
			`PRLC_SWUP_LO:  rdata = swup_q[31:0];
			`PRLC_SWUP_HI:  rdata = {16'h0000, swup_q[47:32]};
			`PRLC_SWLO_LO:  rdata = swlo_q[31:0];
			`PRLC_SWLO_HI:  rdata = {16'h0000, swlo_q[47:32]};
			`PRLC_STATUS:   rdata = status_w;
			`PRLC_IRQ_STAT: rdata = {28'h000_0000, ev_q};
			`PRLC_IRQ_MASK: rdata = {28'h000_0000, mask_q};
			`PRLC_POS_LO:   rdata = pos_q[31:0];
			`PRLC_POS_HI:   rdata = {16'h0000, pos_q[47:32]};
			`PRLC_AUX_IDX:  rdata = {29'h0000_0000, aux_idx_q};
			`PRLC_AUX_VAL:  rdata = aux_mem[aux_idx_q];
			default:        rdata = 32'h0000_0000;
		endcase
	end

	// Bus answer and registered outputs
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			irq_o    <= 1'b0;
			busy_o   <= 1'b0;
			stop_o   <= 1'b0;
			pos_o    <= 48'h0000_0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? rdata : 32'h0000_0000;
			irq_o    <= |(ev_q & mask_q);
			busy_o   <= (state_q == ST_MOVE);
			stop_o   <= ev_set[`PRLC_EV_SWLIM]; // R06
			pos_o    <= pos_q;
		end
	end

endmodule // prlc_top

// ### prlc_consts.vh
`ifndef PRLC_CONSTS_VH
`define PRLC_CONSTS_VH

// Register byte offsets
`define PRLC_CTRL       8'h00
`define PRLC_TGT_LO     8'h04
`define PRLC_TGT_HI     8'h08
`define PRLC_SCALE      8'h0C
`define PRLC_SWUP_LO    8'h10
`define PRLC_SWUP_HI    8'h14
`define PRLC_SWLO_LO    8'h18
`define PRLC_SWLO_HI    8'h1C
`define PRLC_STATUS     8'h20
`define PRLC_IRQ_STAT   8'h24
`define PRLC_IRQ_MASK   8'h28
`define PRLC_POS_LO     8'h2C
`define PRLC_POS_HI     8'h30
`define PRLC_AUX_IDX    8'h34
`define PRLC_AUX_VAL    8'h38

// Control bits
`define PRLC_CTRL_EXT   0
`define PRLC_CTRL_START 1
`define PRLC_CTRL_STOP  2

// Status and event bits
`define PRLC_EV_DONE    0
`define PRLC_EV_RANGE   1
`define PRLC_EV_SWLIM   2
`define PRLC_EV_AUX     3
`define PRLC_EV_BUSY    4
`define PRLC_NUM_EV     4

// Reset values
`define PRLC_EXT_RST    1'b0
`define PRLC_SCALE_RST  16'h0001
`define PRLC_SWUP_RST   48'h0000_7FFF_FFFF
`define PRLC_SWLO_RST   48'hFFFF_8000_0000

// Signed 32-bit pulse limits
`define PRLC_MAX32      48'h0000_7FFF_FFFF
`define PRLC_MIN32      48'hFFFF_8000_0000

// Motion step per clock, in pulses
`define PRLC_STEP       48'h0000_0000_0001

`endif

// ### prlc_properties.sv
`timescale 1ns/1ps
module prlc_properties #(
	parameter AUX_N = 8
) (
	// Clock and reset
	input wire        clk_i,
	input wire        rst_i,
	// Bus and axis
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        irq_o,
	input wire        busy_o,
	input wire        stop_o,
	input wire [47:0] pos_o
);
	logic [1:0] start_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Start writes seen in the last two cycles
	always @(posedge clk_i) begin
		if (rst_i)
			start_q <= 2'h0;
		else
			start_q <= {start_q[0], wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[1]};
	end
	sequence ack_pulse_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence stop_pulse_s;
		stop_o ##1 !stop_o;
	endsequence
	ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> ack_pulse_s)
		else $error("ack missing or longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	unmapped_rd_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h38 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	busy_cause_a: assert property ($rose(busy_o) |-> start_q != 2'h0)
		else $error("motion began without a start");
	pos_still_a: assert property ($changed(pos_o) |-> busy_o || $past(busy_o) || $past(busy_o, 2))
		else $error("position moved while idle");
	stop_pulse_a: assert property (stop_o |-> stop_pulse_s)
		else $error("stop not a single pulse");
	stop_halt_a: assert property (stop_o |-> ##[0:2] !busy_o)
		else $error("axis kept moving after stop");
endmodule // prlc_properties
bind prlc_top prlc_properties #(.AUX_N(AUX_N)) chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.irq_o(irq_o),
	.busy_o(busy_o),
	.stop_o(stop_o),
	.pos_o(pos_o)
);

// ### prlc_prog_model.sv
`timescale 1ns/1ps
module prlc_prog_model (
	// Clock and answer
	input  wire        clk_i,
	input  wire        ack_i,
	input  wire [31:0] dat_i,
	// Request
	output logic       cyc_o = 1'b0,
	output logic       stb_o = 1'b0,
	output logic       we_o = 1'b0,
	output logic [7:0] adr_o = 8'h0,
	output logic [3:0] sel_o = 4'h0,
	output logic [31:0] dat_o = 32'h0
);
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hF;
		dat_o <= d;
		@(posedge clk_i);
		while (ack_i !== 1'b1) @(posedge clk_i);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// Released data never shows the last value
		dat_o <= ~d;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask
endmodule // prlc_prog_model

// ### test_position_range_limit_checker.sv
`timescale 1ns/1ps
module test_position_range_limit_checker;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	wire         cyc, stb, we, ack, irq_o, busy_o, stop_o;
	wire  [7:0]  adr;
	wire  [3:0]  sel;
	wire  [31:0] wd, rdat;
	wire  [47:0] pos_o;
	logic [31:0] rv;
	logic [81:0] tv [8];
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cyc_n = 0;
	int          stops = 0;
	always #2.5 clk_i = ~clk_i;
	prlc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
		.irq_o(irq_o), .busy_o(busy_o), .stop_o(stop_o), .pos_o(pos_o));
	prlc_prog_model prog (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (stop_o === 1'b1)
			stops <= stops + 1;
		if (cyc_n == 20000) begin
			n_mismatch = n_mismatch + 1;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic idle;
		while (busy_o !== 1'b0) @(posedge clk_i);
	endtask
	task automatic go(input logic [31:0] hi, input logic [31:0] lo, input logic e);
		idle();
		prog.wr(8'h04, lo);
		prog.wr(8'h08, hi);
		prog.wr(8'h00, {30'h0, 1'b1, e});
		repeat (2) @(posedge clk_i);
	endtask
	// Row: ext, scale, target high, target low, accepted
	task automatic try(input logic [81:0] t);
		prog.wr(8'h00, {31'h0, t[81]});
		prog.wr(8'h0C, {16'h0, t[80:65]});
		go(t[64:33], t[32:1], t[81]);
		chk("busy", busy_o, t[0]);
		prog.rd(8'h20, rv);
		chk("range", rv[1], !t[0]);
		if (!t[0])
			chk("pos", pos_o, 48'h0);
		if (t[0])
			prog.wr(8'h00, {29'h0, 1'b1, 1'b0, t[81]});
		go(32'h0, 32'h0, t[81]);
		idle();
	endtask
	initial begin
		tv = '{{1'b0, 16'h1, 32'h0, 32'h7FFF_FFFF, 1'b1}, {1'b0, 16'h1, 32'h0, 32'h8000_0000, 1'b0},
			{1'b0, 16'h1, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 1'b0}, {1'b0, 16'h2, 32'h0, 32'h4000_0000, 1'b0},
			{1'b1, 16'h1, 32'h0, 32'h8000_0000, 1'b1}, {1'b1, 16'h1, 32'h7FFF, 32'hFFFF_FFFF, 1'b1},
			{1'b1, 16'h1, 32'h8000, 32'h0, 1'b0}, {1'b1, 16'h1, 32'hFFFF_7FFF, 32'hFFFF_FFFF, 1'b0}};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		prog.rd(8'h00, rv);
		chk("ext", rv[0], 1'b0);
		prog.rd(8'h20, rv);
		chk("limits on", rv[5], 1'b0);
		prog.rd(8'h3C, rv);
		chk("unmapped", rv, 32'h0);
		foreach (tv[i])
			try(tv[i]);
		prog.rd(8'h00, rv);
		chk("ext", rv[0], 1'b1);
		prog.rd(8'h20, rv);
		chk("limits on", rv[5], 1'b1);
		prog.wr(8'h10, 32'h5);
		go(32'h0, 32'h14, 1'b1);
		idle();
		chk("pos", pos_o, 48'h5);
		chk("stops", stops, 1);
		prog.rd(8'h20, rv);
		chk("swlim", rv[2], 1'b1);
		prog.wr(8'h18, 32'h5);
		prog.wr(8'h1C, 32'h0);
		prog.rd(8'h20, rv);
		chk("limits on", rv[5], 1'b0);
		go(32'h0, 32'h1E, 1'b1);
		idle();
		chk("pos", pos_o, 48'h1E);
		prog.wr(8'h0C, 32'h2);
		prog.wr(8'h34, 32'h0);
		prog.wr(8'h38, 32'h7);
		prog.rd(8'h38, rv);
		chk("aux", rv, 32'hE);
		prog.wr(8'h38, 32'h4000_0000);
		prog.rd(8'h38, rv);
		chk("aux", rv, 32'hE);
		repeat (2) @(posedge clk_i);
		chk("irq masked", irq_o, 1'b0);
		prog.wr(8'h28, 32'h8);
		repeat (2) @(posedge clk_i);
		chk("irq", irq_o, 1'b1);
		prog.rd(8'h24, rv);
		chk("aux event", rv[3], 1'b1);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", irq_o, 1'b0);
		report_and_stop();
	end
endmodule // test_position_range_limit_checker
